// File: core/dbs_pkg.sv
// Shared constants and types for the burst SRAM port.
// Assumes one core clock that oversamples both link clocks.
package dbs_pkg;
    // Word and address geometry
    localparam int DATA_W = 36;
    localparam int ADDR_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 4;
    localparam int WORD_AW = ADDR_W + 1;
    localparam int MEM_WORDS = 1 << WORD_AW;
    // Read latency in link half-cycles
    localparam int LAT_PLL_PH = 5;
    localparam int LAT_LEG_PH = 2;
    localparam int PIPE_D = 5;

    // Synchronised pin group
    typedef struct packed {
        logic load_n;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic [LANES-1:0] bws_n;
        logic pll;
    } dbs_pins_t;

    // One pending read in the latency pipe
    typedef struct packed {
        logic v;
        logic [ADDR_W-1:0] a;
    } dbs_slot_t;

    // Write burst progress
    typedef enum logic [1:0] {
        WR_IDLE,
        WR_LO,
        WR_HI
    } dbs_wr_t;

    // Whole state of the port
    typedef struct packed {
        dbs_pins_t p1;
        dbs_pins_t p2;
        logic k1;
        logic k2;
        logic k3;
        logic kn1;
        logic kn2;
        logic kn3;
        logic took;
        dbs_slot_t [PIPE_D-1:0] rq;
        dbs_wr_t wst;
        logic [ADDR_W-1:0] wa;
        logic [DATA_W-1:0] dq;
        logic oe;
        logic vld;
        logic second;
        logic [ADDR_W-1:0] ra;
        logic cq;
        logic cqn;
    } dbs_st_t;

    // Value after reset; the complementary clock idles high, so its
    // synchroniser stages start high and no false edge follows reset
    localparam dbs_st_t ST_RST = '{kn1: 1'b1, kn2: 1'b1, kn3: 1'b1, wst: WR_IDLE, default: '0};
endpackage

// File: core/dbs_port.sv
// Double-data-rate burst SRAM port with its storage array.
// Assumes the link clocks are much slower than i_core_clk
// (at least four core cycles per half link period).
`timescale 1ns/1ns
`default_nettype none
module dbs_port
    import dbs_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_k,
    input wire logic i_k_n,
    input wire logic i_load_strobe_n,
    input wire logic i_read,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_dq,
    input wire logic [LANES-1:0] i_byte_write_select_n,
    input wire logic i_pll_mode_select,
    output logic [DATA_W-1:0] o_dq,
    output logic o_dq_oe,
    output logic o_echo_clock,
    output logic o_echo_clock_n,
    output logic o_read_valid_flag
);

    // Registered state and its next value
    dbs_st_t s_q;
    dbs_st_t s_d;
    // Storage, one entry per word of a burst
    logic [DATA_W-1:0] mem [0:MEM_WORDS-1];
    // Pin group gathered for the synchroniser
    dbs_pins_t pins;
    // Rising edges of the two link clocks
    logic k_rise;
    logic kn_rise;
    logic tick;
    // Burst address taken this cycle
    logic accept;
    // Read launch control
    int unsigned lat;
    dbs_slot_t head;
    logic launch;
    logic [WORD_AW-1:0] rd_idx;
    logic [DATA_W-1:0] rd_word;
    // Array write port
    logic wr_en;
    logic [WORD_AW-1:0] wr_idx;

    always_comb begin
        pins.load_n = i_load_strobe_n;
        pins.rd = i_read;
        pins.addr = i_addr;
        pins.dq = i_dq;
        pins.bws_n = i_byte_write_select_n;
        pins.pll = i_pll_mode_select;
    end

    // Edges found from the second and third stages only
    assign k_rise = s_q.k2 & ~s_q.k3;
    assign kn_rise = s_q.kn2 & ~s_q.kn3;
    assign tick = k_rise | kn_rise;
    // A load right after a taken one is ignored
    assign accept = k_rise & ~s_q.p2.load_n & ~s_q.took;

    // Mode pin picks how deep in the pipe a read launches
    assign lat = s_q.p2.pll ? LAT_PLL_PH : LAT_LEG_PH;
    assign head = s_q.rq[lat-1];
    assign launch = tick & head.v;
    // First word of a new burst, else second of the current
    assign rd_idx = launch ? {head.a, 1'b0} : {s_q.ra, 1'b1};
    assign rd_word = mem[rd_idx];

    // Write words land at the next true edge, then complementary
    assign wr_en = (k_rise & (s_q.wst == WR_LO))
        | (kn_rise & (s_q.wst == WR_HI));
    assign wr_idx = {s_q.wa, s_q.wst == WR_HI};

    // Next-state logic for the whole port
    always_comb begin
        s_d = s_q;
        // Two flops on every pin before use
        s_d.p1 = pins;
        s_d.p2 = s_q.p1;
        s_d.k1 = i_k;
        s_d.k2 = s_q.k1;
        s_d.k3 = s_q.k2;
        s_d.kn1 = i_k_n;
        s_d.kn2 = s_q.kn1;
        s_d.kn3 = s_q.kn2;
        // Echo clocks retimed like the data, so they stay aligned
        s_d.cq = s_q.k2;
        s_d.cqn = s_q.kn2;
        if (k_rise) begin
            s_d.took = accept;
        end
        // Latency pipe steps once per half link cycle
        if (tick) begin
            s_d.rq = {s_q.rq[PIPE_D-2:0], dbs_slot_t'('0)};
            if (accept && s_q.p2.rd) begin
                s_d.rq[0].v = 1'b1;
                s_d.rq[0].a = s_q.p2.addr;
            end
        end
        // Read data launch, output register on link edges
        if (launch) begin
            s_d.dq = rd_word;
            s_d.oe = 1'b1;
            s_d.vld = 1'b1;
            s_d.second = 1'b1;
            s_d.ra = head.a;
        end else if (tick && s_q.second) begin
            s_d.dq = rd_word;
            s_d.second = 1'b0;
        end else if (tick) begin
            // Nothing to send: release the pins
            s_d.oe = 1'b0;
            s_d.vld = 1'b0;
        end
        // Write burst sequencing
        case (s_q.wst)
            WR_IDLE: begin
                if (accept && !s_q.p2.rd) begin
                    s_d.wst = WR_LO;
                    s_d.wa = s_q.p2.addr;
                end
            end
            WR_LO: begin
                if (k_rise) begin
                    s_d.wst = WR_HI;
                end
            end
            WR_HI: begin
                if (kn_rise) begin
                    s_d.wst = WR_IDLE;
                end
            end
            default: begin
                s_d.wst = WR_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Array write, merged per byte lane; no outside timing needed
    // Not reset: contents are undefined until written
    always_ff @(posedge i_core_clk) begin
        if (wr_en) begin
            for (int i = 0; i < LANES; i++) begin
                if (!s_q.p2.bws_n[i]) begin
                    mem[wr_idx][i*LANE_W +: LANE_W] <= s_q.p2.dq[i*LANE_W +: LANE_W];
                end
            end
        end
    end

    // Outputs straight from flops
    assign o_dq = s_q.dq;
    assign o_dq_oe = s_q.oe;
    assign o_echo_clock = s_q.cq;
    assign o_echo_clock_n = s_q.cqn;
    assign o_read_valid_flag = s_q.vld;

    // Checks tied to the link timing of the bench
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_b);

    // A read burst address taken
    sequence s_rd_acc;
        accept && s_q.p2.rd;
    endsequence
    // A write burst address taken
    sequence s_wr_acc;
        accept && !s_q.p2.rd;
    endsequence
    // Data starts to show on the pins
    sequence s_vld_up;
        $rose(o_read_valid_flag);
    endsequence
    // A link edge with no word left to send
    sequence s_no_data;
        tick && !launch && !s_q.second;
    endsequence
    // The edge that moves a burst on to its second word
    sequence s_word_two;
        tick && s_q.second && !launch;
    endsequence

    // Timing assumed by the windows below: each link half period
    // spans four core cycles, so one link phase is four cycles and
    // a whole link period eight. The windows carry at least a cycle of slack
    // on each side for the synchroniser. Faster link clocks would
    // need narrower windows; slower ones wider.
    // The checks watch the internal strobes as well as the pins,
    // so a fault is caught at the stage where it starts rather
    // than only where it reaches the outputs.

    a_addr_alternate: assert property (accept |=> !accept [*8])
        else $error("burst address taken on adjacent edge");
    a_legacy_lat: assert property ((s_rd_acc and !s_q.p2.pll) |-> ##[7:10] s_vld_up)
        else $error("legacy read data not at one cycle");
    a_pll_lat: assert property ((s_rd_acc and s_q.p2.pll) |-> ##[19:22] s_vld_up)
        else $error("read data not at two and a half cycles");
    a_valid_len: assert property (s_vld_up |-> ##[6:10] $fell(o_read_valid_flag))
        else $error("valid flag length wrong for a burst");
    a_idle_hiz: assert property (!o_read_valid_flag |-> !o_dq_oe)
        else $error("data pins driven without read data");
    a_echo_follow: assert property (k_rise |=> o_echo_clock)
        else $error("echo clock not following input clock");
    a_launch_edge: assert property (s_vld_up |-> $past(tick))
        else $error("read launch off a link edge");
    a_write_first: assert property (s_wr_acc |-> ##[7:9] (wr_en && !wr_idx[0]))
        else $error("first write word not taken");
    a_write_second: assert property ((wr_en && !wr_idx[0]) |-> ##[3:5] (wr_en && wr_idx[0]))
        else $error("second write word not taken");
    // Flag only drops at a link edge, so judge it where one falls
    a_quiet_write: assert property ((s_q.rq == '0 && !s_q.second && tick) |=> !o_read_valid_flag)
        else $error("valid flag raised with no read pending");

    // Flag and driver move together, one register each
    a_flag_drive_pair: assert property (o_read_valid_flag == o_dq_oe)
        else $error("valid flag and data driver disagree");

    // Complementary echo follows its input clock up
    a_echo_n_follow: assert property (kn_rise |=> o_echo_clock_n)
        else $error("complementary echo not following its clock");

    // Echo falls one cycle after the synced clock falls
    a_echo_low: assert property ((s_q.k3 && !s_q.k2) |=> !o_echo_clock)
        else $error("echo clock not falling with input clock");

    // A taken load is remembered so the next edge is refused
    a_load_marked: assert property (accept |=> s_q.took)
        else $error("taken load not remembered");

    // Second word keeps the flag up and ends the burst
    a_word_two: assert property (s_word_two |=> (o_read_valid_flag && !s_q.second))
        else $error("second read word not sent");

    // Write burst closes at the complementary edge
    a_write_done: assert property ((s_q.wst == WR_HI && kn_rise) |=> (s_q.wst == WR_IDLE))
        else $error("write burst not closed");

    // A taken read enters the latency pipe at once
    a_read_queued: assert property (s_rd_acc |=> s_q.rq[0].v)
        else $error("read not queued");

    // A taken write keeps the address it was given
    a_write_addr: assert property (s_wr_acc |=> (s_q.wa == $past(s_q.p2.addr)))
        else $error("write address not kept");

    // Pins let go when a link edge brings no word
    a_release_pins: assert property (s_no_data |=> !o_dq_oe)
        else $error("data pins still driven after burst");

    // A launch raises the flag at the next cycle
    a_launch_valid: assert property (launch |=> o_read_valid_flag)
        else $error("launch without valid flag");

    // First word on the pins is the word read at launch
    a_word_one_data: assert property (launch |=> (o_dq == $past(rd_word)))
        else $error("first read word not registered");

    // Array writes only ever happen at a link clock rise
    a_write_rise_only: assert property (wr_en |-> tick)
        else $error("array write off a link edge");

endmodule // dbs_port
`default_nettype wire

// File: tb/dbs_ctl_model.sv
// Controller model: drives link clocks, bursts and byte lanes.
// Assumes i_dq is the resolved shared data wire.
`timescale 1ns/1ns
`default_nettype none
module dbs_ctl_model
    import dbs_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic [DATA_W-1:0] i_dq,
    input wire logic i_dq_oe,
    input wire logic i_read_valid_flag,
    output logic o_k = 1'b0,
    output logic o_k_n = 1'b1,
    output logic o_load_strobe_n = 1'b1,
    output logic o_read = 1'b0,
    output logic [ADDR_W-1:0] o_addr = '0,
    output logic [DATA_W-1:0] o_dq = '0,
    output logic [LANES-1:0] o_byte_write_select_n = '1
);
    // Half link period; pins hold two core cycles round each edge
    task automatic step(input logic kv);
        repeat (2) @(posedge i_core_clk);
        #1;
        o_k = kv;
        o_k_n = !kv;
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask
    // Write: word0 at the next K rise, word1 at the K# rise after
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w0, w1,
        input logic [LANES-1:0] b0, b1, output logic busy);
        o_load_strobe_n = 1'b0;
        o_read = 1'b0;
        o_addr = a;
        step(1'b1);
        o_load_strobe_n = 1'b1;
        step(1'b0);
        o_dq = w0;
        o_byte_write_select_n = b0;
        step(1'b1);
        busy = i_read_valid_flag | i_dq_oe;
        o_dq = w1;
        o_byte_write_select_n = b1;
        step(1'b0);
        busy |= i_read_valid_flag | i_dq_oe;
        // Released data shows the inverse, never a stale copy
        o_dq = ~w1;
        o_byte_write_select_n = '1;
    endtask
    // Read; dbl keeps the strobe low over the following K rise
    task automatic rd(input logic [ADDR_W-1:0] a, input int lat, input logic dbl,
        output logic [DATA_W-1:0] w0, w1, output logic v, vz);
        v = 1'b1;
        o_load_strobe_n = 1'b0;
        o_read = 1'b1;
        o_addr = a;
        step(1'b1);
        o_load_strobe_n = !dbl;
        o_addr = ~a;
        for (int i = 1; i <= lat + 3; i++) begin
            step(i[0] == 1'b0);
            if (i == 2) o_load_strobe_n = 1'b1;
            // Capture where the mode pin puts the words
            if (i == lat + 1) w0 = i_dq;
            if (i == lat + 2) w1 = i_dq;
            if (i == lat + 1 || i == lat + 2) v &= i_read_valid_flag & i_dq_oe;
            if (i == lat + 3) vz = i_read_valid_flag | i_dq_oe;
        end
        if (o_k) step(1'b0);
    endtask
endmodule // dbs_ctl_model
`default_nettype wire

// File: tb/dbs_port_bench.sv
// Self-checking bench for the burst SRAM port.
// Assumes the controller model drives every link pin except the mode pin, which the bench sets.
`timescale 1ns/1ns
`default_nettype none
module dbs_port_bench
    import dbs_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic pll = 1'b0;
    logic k, k_n, load_n, is_rd, oe, echo, echo_n, vld, busy, v, vz;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] q, d, bus, r0, r1;
    logic [LANES-1:0] lanes_n;
    int err_total = 0;
    int n_compared = 0;
    // Shared data wire: the port wins only while its driver is on
    assign bus = oe ? q : d;
    always #20 clk = ~clk;
    dbs_port i_dbs_port (.i_core_clk(clk), .i_rst_b(rst_b), .i_k(k), .i_k_n(k_n),
        .i_load_strobe_n(load_n), .i_read(is_rd), .i_addr(addr), .i_dq(bus),
        .i_byte_write_select_n(lanes_n), .i_pll_mode_select(pll), .o_dq(q),
        .o_dq_oe(oe), .o_echo_clock(echo), .o_echo_clock_n(echo_n),
        .o_read_valid_flag(vld));
    dbs_ctl_model i_dbs_ctl_model (.i_core_clk(clk), .i_dq(bus), .i_dq_oe(oe),
        .i_read_valid_flag(vld), .o_k(k), .o_k_n(k_n), .o_load_strobe_n(load_n),
        .o_read(is_rd), .o_addr(addr), .o_dq(d), .o_byte_write_select_n(lanes_n));
    task automatic chk_w(input logic [DATA_W-1:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_f(input logic got, exp);
        chk_w({35'h0, got}, {35'h0, exp});
    endtask
    task automatic print_verdict;
        $display("Compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One read burst, judging both words and the valid window
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input int lat, input logic dbl,
        input logic [DATA_W-1:0] e0, e1);
        i_dbs_ctl_model.rd(a, lat, dbl, r0, r1, v, vz);
        chk_w(r0, e0);
        chk_w(r1, e1);
        chk_f(v, 1'b1);
        chk_f(vz, 1'b0);
    endtask
    // Idle port, then echo clocks retracing K and K#
    task automatic t_echo;
        chk_f(vld, 1'b0);
        chk_f(oe, 1'b0);
        for (int i = 1; i >= 0; i--) begin
            i_dbs_ctl_model.step(i[0]);
            repeat (2) @(posedge clk);
            #1;
            chk_f(echo, i[0]);
            chk_f(echo_n, !i[0]);
        end
        $display("t_echo done");
    endtask
    // Legacy latency: top address written, then read back
    task automatic t_rw;
        i_dbs_ctl_model.wr(18'h3FFFF, 36'h123456789, 36'h9ABCDEF01, 4'h0, 4'h0, busy);
        chk_f(busy, 1'b0);
        rd_chk(18'h3FFFF, 2, 1'b0, 36'h123456789, 36'h9ABCDEF01);
        $display("t_rw done");
    endtask
    // Lanes 0,2 on word0, lane 0 on word1; then a refused second load
    task automatic t_lanes;
        i_dbs_ctl_model.wr(18'h00000, '1, '0, 4'h0, 4'h0, busy);
        i_dbs_ctl_model.wr(18'h00000, '0, '1, 4'hA, 4'hE, busy);
        rd_chk(18'h00000, 2, 1'b0, 36'hFF803FE00, 36'h0000001FF);
        rd_chk(18'h00000, 2, 1'b1, 36'hFF803FE00, 36'h0000001FF);
        $display("t_lanes done");
    endtask
    // 2.5 cycle mode: words five half cycles after the load
    task automatic t_pll;
        pll = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        rd_chk(18'h3FFFF, 5, 1'b0, 36'h123456789, 36'h9ABCDEF01);
        pll = 1'b0;
        $display("t_pll done");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        t_echo;
        t_rw;
        t_lanes;
        t_pll;
        print_verdict;
    end
    // Run needs about 8 us; a hang ends it as failed
    initial begin
        #100000;
        err_total++;
        print_verdict;
    end
endmodule // dbs_port_bench
`default_nettype wire
